// *** stl1_map.svh ***
`ifndef STL1_MAP_SVH
`define STL1_MAP_SVH
// Behaviour
// - Command 0000 starts full deactivation sending INFO 0; NT accepts it in any G1, G2 or G3 state.
// - Command 0001 resets the machine anywhere; sends INFO 0, ignores line.
// - Commands 0010/0011 enter single or continuous pulse test modes.
// - Command 1000 starts an exchange-initiated activation.
// - Command 1010 activates with the analog loop-back near the line.
// - Command 1111 enters deactivated state with terminal wake detection enabled.
// - LT-S reports 0000 as interim indication in deactivated state G1.
// - Terminal wake signal gives indication 1000 and activation proceeds.
// - Indication 0100 whenever the line receiver is not synchronous in a G2 or G3 state.
// - Indication 1011 on code violation, only with violation reporting enabled.
// - Indication 1100 once receiver is synchronous and activation done.
// - Indication 1111 after 16 ms INFO 0 or 32 ms timeout.
// - G1 sends nothing, may stop clocks, accepts line or channel activation.
// - NT wake detection gives indication 1000 and waits for command.
// - NT pending activation sends INFO 2; loop request closes loop 2.
// - NT keeps INFO 2 after INFO 3 until switch-through command.
// - Switch-through sends INFO 4 transparently; loop variant closes loop 2.
// - Lost receiver sync in G3 moves to the lost framing state.
// - NT command 0100 makes the device send INFO 2.
// - After deactivation the device waits until deactivation confirm.
// - LT-S receiver classes: INFO 0, level, INFO 3, other INFO.

// ----------------------------------------
// Command codes
// ----------------------------------------
`define STL1_C_DEACT_REQ 4'h0
`define STL1_C_RESET 4'h1
`define STL1_C_SINGLE_PULSE 4'h2
`define STL1_C_CONT_PULSE 4'h3
`define STL1_C_UP_UNSYNC 4'h4
`define STL1_C_ACT_REQ 4'h8
`define STL1_C_LOOP_ACT_REQ 4'hA
`define STL1_C_SWITCH_THROUGH 4'hC
`define STL1_C_LOOP_SWITCH 4'hE
`define STL1_C_DEACT_CONFIRM 4'hF

// ----------------------------------------
// Indication codes
// ----------------------------------------
`define STL1_I_INTERIM 4'h0
`define STL1_I_UNSYNCED 4'h4
`define STL1_I_ACT_REQ 4'h8
`define STL1_I_CODE_VIOL 4'hB
`define STL1_I_ACT_DONE 4'hC
`define STL1_I_DEACT_DONE 4'hF

// ----------------------------------------
// Timing
// ----------------------------------------
`define STL1_CLK_KHZ 250000
`define STL1_MS_CYCLES (`STL1_CLK_KHZ * 1)
`define STL1_T_QUIET_MS 16
`define STL1_T_DEACT_MS 32
`endif

// *** stl1_pkg.sv ***
package stl1_pkg;
	// Gray codes along the NT activation path
	typedef enum logic [3:0] {
		ST_G1_DEACT = 4'h0,
		ST_G1_WAKE = 4'h1,
		ST_G2_PEND = 4'h3,
		ST_G2_WAIT = 4'h2,
		ST_G3_ACT = 4'h6,
		ST_G2_LOST_LINE = 4'h7,
		ST_G3_LOST_UP = 4'h5,
		ST_G4_PEND = 4'h4,
		ST_G4_WAIT = 4'hC,
		ST_TEST_SINGLE = 4'hD,
		ST_TEST_CONT = 4'hF,
		ST_RESET = 4'hE
	} stl1_state_t;

	typedef enum logic [2:0] {
		TX_INFO0 = 3'h0,
		TX_INFO2 = 3'h1,
		TX_INFO4 = 3'h2,
		TX_SINGLE = 3'h3,
		TX_CONT = 3'h4
	} stl1_tx_t;

	typedef struct packed {
		stl1_state_t state;
		logic [3:0] ind;
		stl1_tx_t tx;
		logic loop2;
		logic xparent;
		logic clk_off;
		logic cv_seen;
		logic [5:0] deact_ms;
		logic [4:0] quiet_ms;
	} stl1_fsm_reg_t;
endpackage

// *** stl1_ms_tick.sv ***
`timescale 1ns/1ns
`include "stl1_map.svh"
module stl1_ms_tick
	import stl1_pkg::*;
#(
	parameter int unsigned CYCLES = `STL1_MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Restart the period
	input wire logic clr_i,
	// One-cycle pulse per period
	output logic tick_o
);
	localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} stl1_tick_reg_t;

	stl1_tick_reg_t r;
	stl1_tick_reg_t next_r;

	if (CYCLES < 2) begin : g_bad_cycles
		$error("stl1_ms_tick: CYCLES must be at least 2");
	end

	// Period counter; a clear restarts it so the first tick is a full period away
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (clr_i) begin
			next_r.cnt = '0;
		end else if (r.cnt == W'(CYCLES - 1)) begin
			next_r.cnt = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick_o = r.tick;
endmodule // stl1_ms_tick

// *** stl1_fsm.sv ***
`timescale 1ns/1ns
`include "stl1_map.svh"
module stl1_fsm
	import stl1_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `STL1_MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration
	input wire logic nt_mode_i,
	input wire logic code_violation_enable_i,
	input wire logic clock_stop_on_deactivate_i,
	// Control channel
	input wire logic frame_i,
	input wire logic [3:0] cmd_i,
	output logic [3:0] ind_o,
	// Line receiver classes
	input wire logic rx_info0_i,
	input wire logic rx_level_i,
	input wire logic rx_info3_i,
	input wire logic rx_sync_i,
	input wire logic rx_cv_i,
	// Line side control
	output stl1_tx_t tx_info_o,
	output logic loop2_o,
	output logic transparent_o,
	output logic clocks_off_o
);
	// ----------------------------------------
	// State and timers
	// ----------------------------------------
	stl1_fsm_reg_t r;
	stl1_fsm_reg_t next_r;
	logic deact_tick;
	logic quiet_tick;
	logic in_deact;
	logic timer_done;
	logic in_test;
	logic test_cmd;
	logic dr_ok;
	logic active;
	logic [3:0] ind_now;

	if (MS_CYCLES < 2) begin : g_bad_ms
		$error("stl1_fsm: MS_CYCLES must be at least 2");
	end

	assign in_deact = (r.state == ST_G4_PEND);

	// Overall deactivation timer, started on entry to pending deactivation
	stl1_ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_deact_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!in_deact),
		.tick_o(deact_tick)
	);

	// Quiet-line timer, restarted by every cycle of line activity
	stl1_ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_quiet_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!in_deact || !rx_info0_i),
		.tick_o(quiet_tick)
	);

	assign timer_done = (r.deact_ms == 6'(`STL1_T_DEACT_MS))
		|| (r.quiet_ms == 5'(`STL1_T_QUIET_MS));

	// ----------------------------------------
	// Command classification
	// ----------------------------------------
	assign in_test = (r.state == ST_TEST_SINGLE) || (r.state == ST_TEST_CONT);
	assign test_cmd = (cmd_i == `STL1_C_SINGLE_PULSE) || (cmd_i == `STL1_C_CONT_PULSE);
	// NT takes deactivation outside the G4 states; LT-S also refuses it in ST_G1_DEACT
	always_comb begin
		dr_ok = (r.state != ST_G4_PEND) && (r.state != ST_G4_WAIT);
		if (!nt_mode_i) begin
			dr_ok = dr_ok && (r.state != ST_G1_DEACT);
		end
	end
	assign active = (r.state == ST_G2_PEND) || (r.state == ST_G2_WAIT)
		|| (r.state == ST_G3_ACT) || (r.state == ST_G2_LOST_LINE)
		|| (r.state == ST_G3_LOST_UP);

	// ----------------------------------------
	// Indication, taken from the state held before this frame's step
	// ----------------------------------------
	always_comb begin
		case (r.state)
			ST_G1_WAKE: ind_now = `STL1_I_ACT_REQ;
			ST_G3_ACT: ind_now = `STL1_I_ACT_DONE;
			ST_G4_WAIT: ind_now = `STL1_I_DEACT_DONE;
			ST_G2_PEND,
			ST_G2_WAIT,
			ST_G2_LOST_LINE,
			ST_G3_LOST_UP: ind_now = `STL1_I_ACT_REQ;
			default: ind_now = `STL1_I_INTERIM;
		endcase
		// Loss of sync outranks a violation report
		if (active && !rx_sync_i) begin
			ind_now = `STL1_I_UNSYNCED;
		end else if (r.cv_seen) begin
			ind_now = `STL1_I_CODE_VIOL;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		// Deactivation timers only run in pending deactivation
		if (!in_deact) begin
			next_r.deact_ms = '0;
			next_r.quiet_ms = '0;
		end else begin
			if (deact_tick && !timer_done) begin
				next_r.deact_ms = r.deact_ms + 1'b1;
			end
			if (!rx_info0_i) begin
				next_r.quiet_ms = '0;
			end else if (quiet_tick && !timer_done) begin
				next_r.quiet_ms = r.quiet_ms + 1'b1;
			end
		end
		// Commands are sampled only on the frame strobe
		if (frame_i) begin
			next_r.ind = ind_now;
			next_r.cv_seen = 1'b0;
			if (cmd_i == `STL1_C_RESET) begin
				next_r.state = ST_RESET;
			end else if (test_cmd && !in_test) begin
				next_r.state = (cmd_i == `STL1_C_CONT_PULSE) ?
					ST_TEST_CONT : ST_TEST_SINGLE;
			end else if (in_test) begin
				// Controller never swaps test modes directly
				if (!test_cmd) begin
					next_r.state = ST_G1_DEACT;
				end
			end else if (r.state == ST_RESET) begin
				next_r.state = ST_G1_DEACT;
			end else if (cmd_i == `STL1_C_DEACT_REQ && dr_ok) begin
				next_r.state = ST_G4_PEND;
			end else begin
				case (r.state)
					ST_G1_DEACT: begin
						if (cmd_i == `STL1_C_ACT_REQ) begin
							next_r.state = ST_G2_PEND;
						end else if (cmd_i == `STL1_C_LOOP_ACT_REQ) begin
							next_r.state = ST_G2_PEND;
							next_r.loop2 = 1'b1;
						end else if (rx_level_i) begin
							next_r.state = nt_mode_i ? ST_G1_WAKE : ST_G2_PEND;
						end
					end
					ST_G1_WAKE: begin
						// Wait for the upstream activation command
						if (cmd_i == `STL1_C_ACT_REQ) begin
							next_r.state = ST_G2_PEND;
						end else if (cmd_i == `STL1_C_LOOP_ACT_REQ) begin
							next_r.state = ST_G2_PEND;
							next_r.loop2 = 1'b1;
						end
					end
					ST_G2_PEND,
					ST_G2_LOST_LINE: begin
						if (rx_info3_i && rx_sync_i) begin
							next_r.state = nt_mode_i ? ST_G2_WAIT : ST_G3_ACT;
						end
					end
					ST_G2_WAIT,
					ST_G3_LOST_UP: begin
						if (cmd_i == `STL1_C_SWITCH_THROUGH) begin
							next_r.state = ST_G3_ACT;
						end else if (cmd_i == `STL1_C_LOOP_SWITCH) begin
							next_r.state = ST_G3_ACT;
							next_r.loop2 = 1'b1;
						end
					end
					ST_G3_ACT: begin
						if (!rx_sync_i) begin
							next_r.state = ST_G2_LOST_LINE;
						end else if (nt_mode_i && cmd_i == `STL1_C_UP_UNSYNC) begin
							next_r.state = ST_G3_LOST_UP;
						end
					end
					ST_G4_PEND: begin
						if (timer_done) begin
							next_r.state = ST_G4_WAIT;
						end
					end
					ST_G4_WAIT: begin
						if (cmd_i == `STL1_C_DEACT_CONFIRM) begin
							next_r.state = ST_G1_DEACT;
						end
					end
					default: begin
						next_r.state = ST_G1_DEACT;
					end
				endcase
			end
		end
		// Violations caught in the clearing cycle are kept
		if (code_violation_enable_i && rx_cv_i) begin
			next_r.cv_seen = 1'b1;
		end
		// Loop only survives the activation states
		if (next_r.state == ST_G1_DEACT || next_r.state == ST_G1_WAKE
			|| next_r.state == ST_RESET || next_r.state == ST_G4_PEND
			|| next_r.state == ST_G4_WAIT || next_r.state == ST_TEST_SINGLE
			|| next_r.state == ST_TEST_CONT) begin
			next_r.loop2 = 1'b0;
		end
		// Line info follows the next state so outputs leave flops
		case (next_r.state)
			ST_G2_PEND,
			ST_G2_WAIT,
			ST_G2_LOST_LINE,
			ST_G3_LOST_UP: next_r.tx = TX_INFO2;
			ST_G3_ACT: next_r.tx = TX_INFO4;
			ST_TEST_SINGLE: next_r.tx = TX_SINGLE;
			ST_TEST_CONT: next_r.tx = TX_CONT;
			default: next_r.tx = TX_INFO0;
		endcase
		next_r.xparent = (next_r.state == ST_G3_ACT);
		next_r.clk_off = (next_r.state == ST_G1_DEACT)
			&& clock_stop_on_deactivate_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign ind_o = r.ind;
	assign tx_info_o = r.tx;
	assign loop2_o = r.loop2;
	assign transparent_o = r.xparent;
	assign clocks_off_o = r.clk_off;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_reset_cmd;
		frame_i && cmd_i == `STL1_C_RESET;
	endsequence

	sequence s_quiet_line;
		r.state == ST_RESET && tx_info_o == TX_INFO0;
	endsequence

	sequence s_timeout;
		frame_i && in_deact && timer_done && cmd_i != `STL1_C_RESET && !test_cmd;
	endsequence

	// Pending state has been left for the final wait, still silent on the line
	sequence s_done_reported;
		r.state == ST_G4_WAIT && tx_info_o == TX_INFO0;
	endsequence

	a_reset_cmd_quiet: assert property (s_reset_cmd |=> s_quiet_line)
		else $error("reset command did not silence the line");

	a_nt_deact_any: assert property (frame_i && nt_mode_i && dr_ok
		&& cmd_i == `STL1_C_DEACT_REQ && !in_test && r.state != ST_RESET
		|=> r.state == ST_G4_PEND && tx_info_o == TX_INFO0)
		else $error("deactivation request not taken");

	a_test_entry: assert property (frame_i && test_cmd && !in_test
		|=> tx_info_o == ($past(cmd_i[0]) ? TX_CONT : TX_SINGLE))
		else $error("pulse test mode not entered");

	// Clock-stop flop still holds its reset value in the first cycle after release
	a_g1_idle_line: assert property (r.state == ST_G1_DEACT && !$past(rst_i)
		|-> tx_info_o == TX_INFO0 && clocks_off_o == $past(clock_stop_on_deactivate_i))
		else $error("deactivated state drives the line or clocks wrongly");

	a_timeout_report: assert property (s_timeout |=> s_done_reported)
		else $error("deactivation timer did not end pending state");

	a_deact_bound: assert property (in_deact |-> r.deact_ms <= 6'(`STL1_T_DEACT_MS))
		else $error("deactivation counter ran past its limit");

	a_lost_sync: assert property (frame_i && r.state == ST_G3_ACT && !rx_sync_i
		&& cmd_i == `STL1_C_ACT_REQ |=> r.state == ST_G2_LOST_LINE
		##0 tx_info_o == TX_INFO2)
		else $error("sync loss in G3 not handled");

	a_wait_holds: assert property (frame_i && r.state == ST_G4_WAIT
		&& cmd_i == `STL1_C_ACT_REQ |=> r.state == ST_G4_WAIT)
		else $error("left final wait without confirmation");

	a_act_done_ind: assert property (frame_i && r.state == ST_G3_ACT
		&& rx_sync_i && !r.cv_seen |=> ind_o == `STL1_I_ACT_DONE)
		else $error("activation indication missing");

	a_cv_gated: assert property (frame_i && !r.cv_seen
		|=> ind_o != `STL1_I_CODE_VIOL)
		else $error("violation reported without being seen");

	a_ind_frame_only: assert property (!frame_i |=> $stable(ind_o))
		else $error("indication changed between frames");

	a_nt_hold_info2: assert property (r.state == ST_G2_WAIT
		|-> tx_info_o == TX_INFO2 && !transparent_o)
		else $error("NT wait state not sending INFO 2");

	// Indications and transitions that only a particular command or line class can trigger
	a_sync_ind: assert property (frame_i && active && !rx_sync_i
		|=> ind_o == `STL1_I_UNSYNCED)
		else $error("unsynchronised receiver not reported");

	a_loop_closed: assert property (frame_i && r.state == ST_G1_DEACT
		&& cmd_i == `STL1_C_LOOP_ACT_REQ |=> loop2_o && tx_info_o == TX_INFO2)
		else $error("loop activation did not close the loop");

	a_switch_through: assert property (frame_i && r.state == ST_G2_WAIT
		&& cmd_i == `STL1_C_SWITCH_THROUGH |=> transparent_o && tx_info_o == TX_INFO4)
		else $error("switch-through did not send INFO 4");

	a_up_unsync: assert property (frame_i && nt_mode_i && r.state == ST_G3_ACT
		&& rx_sync_i && cmd_i == `STL1_C_UP_UNSYNC
		|=> r.state == ST_G3_LOST_UP && tx_info_o == TX_INFO2)
		else $error("upstream sync loss did not send INFO 2");

	a_nt_wake: assert property (frame_i && nt_mode_i && r.state == ST_G1_DEACT
		&& rx_level_i && cmd_i == `STL1_C_DEACT_CONFIRM
		|=> r.state == ST_G1_WAKE && tx_info_o == TX_INFO0)
		else $error("NT wake did not wait for the upstream command");

	a_lts_wake: assert property (frame_i && !nt_mode_i && r.state == ST_G1_DEACT
		&& rx_level_i && cmd_i == `STL1_C_DEACT_CONFIRM
		|=> r.state == ST_G2_PEND && tx_info_o == TX_INFO2)
		else $error("line wake not accepted in deactivated state");
endmodule // stl1_fsm

// *** stl1_term_model.sv ***
`timescale 1ns/1ns
module stl1_term_model
	import stl1_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Bench controls
	input wire logic wake_i,
	input wire logic drop_sync_i,
	input wire logic [7:0] dly_i,
	// Line from the device
	input wire stl1_tx_t tx_info_i,
	// Receiver classes seen by the device
	output logic rx_info0_o,
	output logic rx_level_o,
	output logic rx_info3_o,
	output logic rx_sync_o
);
	logic [7:0] cnt = 8'h00;

	// Cycles since framing started; a slow terminal waits longer before INFO 3
	always_ff @(posedge clk_i) begin
		if (tx_info_i != TX_INFO2 && tx_info_i != TX_INFO4) cnt <= 8'h00;
		else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
	end

	// Sleeping terminal leaves the line quiet
	assign rx_info0_o = !wake_i;
	assign rx_level_o = wake_i;
	assign rx_info3_o = wake_i && cnt != 8'h00 && cnt >= dly_i;
	assign rx_sync_o = rx_info3_o && !drop_sync_i;
endmodule // stl1_term_model

// *** tb_st_layer1_activation_fsm.sv ***
`timescale 1ns/1ns
`include "stl1_map.svh"
module tb_st_layer1_activation_fsm;
	import stl1_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic nt = 1'b0, cve = 1'b0, cso = 1'b1, frm = 1'b0, cv = 1'b0, wake = 1'b0, drop = 1'b0;
	logic [3:0] cmd = 4'h1;
	logic [7:0] dly = 8'h10;
	logic [3:0] ind;
	stl1_tx_t tx;
	logic loop2, xp, ckoff, r0, rl, r3, rs;
	int n_errors = 0;
	int tests_run = 0;
	int n;

	stl1_fsm #(.MS_CYCLES(4)) stl1_fsm_inst (.clk_i(clk_i), .rst_i(rst_i), .nt_mode_i(nt),
		.code_violation_enable_i(cve), .clock_stop_on_deactivate_i(cso), .frame_i(frm),
		.cmd_i(cmd), .ind_o(ind), .rx_info0_i(r0), .rx_level_i(rl), .rx_info3_i(r3),
		.rx_sync_i(rs), .rx_cv_i(cv), .tx_info_o(tx), .loop2_o(loop2), .transparent_o(xp),
		.clocks_off_o(ckoff));
	stl1_term_model stl1_term_model_inst (.clk_i(clk_i), .wake_i(wake), .drop_sync_i(drop),
		.dly_i(dly), .tx_info_i(tx), .rx_info0_o(r0), .rx_level_o(rl), .rx_info3_o(r3),
		.rx_sync_o(rs));

	// Free-running 250 MHz clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One frame; returns once the answer has settled
	task automatic go(input logic [3:0] c);
		@(negedge clk_i);
		frm = 1'b1;
		cmd = c;
		@(negedge clk_i);
		frm = 1'b0;
	endtask
	task automatic till_tx(input logic [3:0] c, input stl1_tx_t e);
		int k;
		k = 0;
		while (tx !== e && k < 50) begin
			go(c);
			k++;
		end
		chk(tx, e);
	endtask
	// Counts frames until the wanted indication, bounded
	task automatic till_ind(input logic [3:0] c, input logic [3:0] e, output int m);
		m = 0;
		while (ind !== e && m < 200) begin
			go(c);
			m++;
		end
		chk(ind, e);
	endtask
	task automatic cvp;
		@(negedge clk_i) cv = 1'b1;
		@(negedge clk_i) cv = 1'b0;
	endtask
	task give_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		chk(ind, 4'h0);
		chk(tx, TX_INFO0);
		chk(loop2, 1'b0);
		chk(ckoff, 1'b1);
		cso = 1'b0;
		repeat (2) @(negedge clk_i);
		chk(ckoff, 1'b0);
		cso = 1'b1;
		wake = 1'b1;
		repeat (3) go(`STL1_C_RESET);
		chk(tx, TX_INFO0);
		chk(ind, 4'h0);
		wake = 1'b0;
		go(`STL1_C_DEACT_CONFIRM);
		$display("test reset done");
	endtask
	task t_lts_act;
		go(`STL1_C_ACT_REQ);
		chk(tx, TX_INFO2);
		chk(ind, `STL1_I_INTERIM);
		chk(ckoff, 1'b0);
		wake = 1'b1;
		go(`STL1_C_ACT_REQ);
		chk(ind, `STL1_I_UNSYNCED);
		till_tx(`STL1_C_ACT_REQ, TX_INFO4);
		chk(ind, `STL1_I_ACT_REQ);
		go(`STL1_C_ACT_REQ);
		chk(ind, `STL1_I_ACT_DONE);
		cve = 1'b1;
		cvp();
		go(`STL1_C_ACT_REQ);
		chk(ind, `STL1_I_CODE_VIOL);
		go(`STL1_C_ACT_REQ);
		chk(ind, `STL1_I_ACT_DONE);
		cve = 1'b0;
		cvp();
		go(`STL1_C_ACT_REQ);
		chk(ind, `STL1_I_ACT_DONE);
		drop = 1'b1;
		go(`STL1_C_ACT_REQ);
		chk(tx, TX_INFO2);
		go(`STL1_C_ACT_REQ);
		chk(ind, `STL1_I_UNSYNCED);
		drop = 1'b0;
		till_tx(`STL1_C_ACT_REQ, TX_INFO4);
		$display("test exchange activation done");
	endtask
	task t_deact;
		go(`STL1_C_DEACT_REQ);
		chk(tx, TX_INFO0);
		till_ind(`STL1_C_DEACT_REQ, `STL1_I_DEACT_DONE, n);
		chk(n >= 60 && n <= 68, 8'h01);
		repeat (3) go(`STL1_C_ACT_REQ);
		chk(ind, `STL1_I_DEACT_DONE);
		wake = 1'b0;
		repeat (2) go(`STL1_C_DEACT_CONFIRM);
		chk(ind, `STL1_I_INTERIM);
		chk(ckoff, 1'b1);
		wake = 1'b1;
		go(`STL1_C_DEACT_CONFIRM);
		chk(tx, TX_INFO2);
		repeat (2) go(`STL1_C_RESET);
		chk(tx, TX_INFO0);
		wake = 1'b0;
		go(`STL1_C_DEACT_CONFIRM);
		$display("test deactivation done");
	endtask
	// Pulse tests are always separated by another command
	task t_test;
		repeat (2) go(`STL1_C_SINGLE_PULSE);
		chk(tx, TX_SINGLE);
		go(`STL1_C_DEACT_CONFIRM);
		chk(tx, TX_INFO0);
		go(`STL1_C_CONT_PULSE);
		chk(tx, TX_CONT);
		go(`STL1_C_DEACT_CONFIRM);
		go(`STL1_C_LOOP_ACT_REQ);
		chk(tx, TX_INFO2);
		chk(loop2, 1'b1);
		go(`STL1_C_RESET);
		go(`STL1_C_DEACT_CONFIRM);
		chk(loop2, 1'b0);
		$display("test pulse and loop done");
	endtask
	task t_nt;
		nt = 1'b1;
		wake = 1'b1;
		repeat (2) go(`STL1_C_DEACT_CONFIRM);
		chk(ind, `STL1_I_ACT_REQ);
		chk(tx, TX_INFO0);
		go(`STL1_C_ACT_REQ);
		chk(tx, TX_INFO2);
		repeat (12) go(`STL1_C_ACT_REQ);
		chk(tx, TX_INFO2);
		chk(xp, 1'b0);
		go(`STL1_C_SWITCH_THROUGH);
		chk(tx, TX_INFO4);
		chk(xp, 1'b1);
		go(`STL1_C_UP_UNSYNC);
		chk(tx, TX_INFO2);
		go(`STL1_C_LOOP_SWITCH);
		chk(loop2, 1'b1);
		wake = 1'b0;
		go(`STL1_C_DEACT_REQ);
		chk(tx, TX_INFO0);
		till_ind(`STL1_C_DEACT_REQ, `STL1_I_DEACT_DONE, n);
		chk(n >= 28 && n <= 36, 8'h01);
		go(`STL1_C_DEACT_CONFIRM);
		chk(loop2, 1'b0);
		$display("test network termination done");
	endtask

	// Main sequence
	initial begin
		repeat (4) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		t_reset();
		t_lts_act();
		t_deact();
		t_test();
		t_nt();
		give_verdict();
	end

	// Watchdog: the whole run needs well under 2000 cycles
	initial begin
		#40000;
		n_errors++;
		give_verdict();
	end
endmodule // tb_st_layer1_activation_fsm
